// file: verilog/synth_ctrl_regs.svh
// Purpose: offsets, field positions, resets, codes
// Assumes: 32-bit register words, byte addresses
// Notes: included by both design modules
`ifndef SYNTH_CTRL_REGS_SVH
`define SYNTH_CTRL_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_FREQ 8'h00
`define OFS_MOD 8'h04
`define OFS_CTRL 8'h08
`define OFS_TIMER 8'h0c
`define OFS_DITHER 8'h10
`define OFS_STATUS 8'h14

// ****************************************
// Field positions
// ****************************************
`define WORD_LSB 3
`define WORD_MSB 14
`define CNT_RST_BIT 3
`define PWR_DN_BIT 5
`define SLIP_EN_BIT 18
`define DIV_MODE_LSB 15
`define DIV_MODE_MSB 16
`define DITHER_BIT 0

// ****************************************
// Reset values and codes
// ****************************************
`define MOD_RESET 12'h002
`define MOD_MIN 12'h002
`define DIV_MODE_OFF 2'h0
`define DIV_MODE_FAST 2'h1
`define MAX_CELLS 3'h7
`define LFSR_SEED 21'h000001
`define LFSR_TAPS 21'h140000

`endif

// file: verilog/synth_ctrl_pkg.sv
// Purpose: shared types of the synthesizer control core
// Assumes: constants come from the register header
// Notes: types only
package synth_ctrl_pkg;

	// ****************************************
	// Charge pump drive towards the analog side
	// ****************************************
	typedef struct packed
	{
		logic boost_x16;
		logic source;
		logic [2:0] cells;
	} cp_drive_s;

	// ****************************************
	// Slip reduction sequencer states
	// ****************************************
	typedef enum logic [1:0]
	{
		SLIP_IDLE,
		SLIP_RAMP,
		SLIP_RELEASE
	} slip_state_e;

endpackage : synth_ctrl_pkg

// file: verilog/sigma_delta3.sv
// Purpose: third-order modulus-based sigma-delta modulator
// Assumes: advance is a one-cycle pulse per PFD period
// Notes: output in -3..+4, registered
`timescale 1ns/1ps
`include "synth_ctrl_regs.svh"

module sigma_delta3 #(
	parameter int MOD_W = 12
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic hold,
	input wire logic advance,
	input wire logic dither_en,
	input wire logic [MOD_W-1:0] modulus,
	input wire logic [MOD_W-1:0] frac,
	output logic signed [3:0] code
);
	import synth_ctrl_pkg::*;

	logic [MOD_W-1:0] acc1;
	logic [MOD_W-1:0] acc2;
	logic [MOD_W-1:0] acc3;
	logic c2_d;
	logic c3_d;
	logic c3_dd;
	logic [20:0] lfsr;
	logic [MOD_W:0] s1;
	logic [MOD_W:0] s2;
	logic [MOD_W:0] s3;
	logic [MOD_W-1:0] f_clip;

	// ****************************************
	// Modulo accumulate, carry in the top bit
	// ****************************************
	function automatic logic [MOD_W:0] mod_add(
		input logic [MOD_W-1:0] acc,
		input logic [MOD_W:0] inc,
		input logic [MOD_W-1:0] m
	);
		logic [MOD_W+1:0] s;
		s = {2'h0, acc} + {1'b0, inc};
		if (s >= {2'h0, m})
		begin
			s = s - {2'h0, m};
			mod_add = {1'b1, s[MOD_W-1:0]};
		end
		else
		begin
			mod_add = {1'b0, s[MOD_W-1:0]};
		end
	endfunction : mod_add

	// Fraction above the modulus would break the modulo step
	assign f_clip = (frac >= modulus) ? modulus - 1'b1 : frac;
	assign s1 = mod_add(acc1, {1'b0, f_clip} +
		{{MOD_W{1'b0}}, dither_en & lfsr[0]}, modulus);
	assign s2 = mod_add(acc2, {1'b0, s1[MOD_W-1:0]}, modulus);
	assign s3 = mod_add(acc3, {1'b0, s2[MOD_W-1:0]}, modulus);

	// ****************************************
	// Dither source, repeat 2^21-1 advances
	// ****************************************
	// long dither sequence
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			lfsr <= `LFSR_SEED;
		else if (clk_en && advance && !hold)
			lfsr <= {1'b0, lfsr[20:1]} ^
				(lfsr[0] ? `LFSR_TAPS : 21'h000000);
	end

	// ****************************************
	// Accumulators and noise shaping
	// ****************************************
	// advance per PFD cycle
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			acc1 <= '0;
			acc2 <= '0;
			acc3 <= '0;
			c2_d <= 1'b0;
			c3_d <= 1'b0;
			c3_dd <= 1'b0;
			code <= 4'sh0;
		end
		else if (clk_en && hold)
		begin
			acc1 <= '0;
			acc2 <= '0;
			acc3 <= '0;
			c2_d <= 1'b0;
			c3_d <= 1'b0;
			c3_dd <= 1'b0;
			code <= 4'sh0;
		end
		else if (clk_en && advance)
		begin
			acc1 <= s1[MOD_W-1:0];
			acc2 <= s2[MOD_W-1:0];
			acc3 <= s3[MOD_W-1:0];
			c2_d <= s2[MOD_W];
			c3_d <= s3[MOD_W];
			c3_dd <= c3_d;
			code <= $signed({3'h0, s1[MOD_W]})
				+ $signed({3'h0, s2[MOD_W]})
				- $signed({3'h0, c2_d})
				+ $signed({3'h0, s3[MOD_W]})
				- $signed({2'h0, c3_d, 1'b0})
				+ $signed({3'h0, c3_dd});
		end
	end

endmodule : sigma_delta3

// file: verilog/synth_ctrl.sv
// Purpose: fractional-N modulator, slip reduction, fast lock
// Assumes: pfd_tick is a one-cycle pulse per PFD period
// Notes: slip pins come from the analog side, synchronised
`timescale 1ns/1ps
`include "synth_ctrl_regs.svh"

module synth_ctrl #(
	parameter int MOD_W = 12
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic pfd_tick,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic slip_near_pin,
	input wire logic overshoot_pin,
	input wire logic tune_up_pin,
	output synth_ctrl_pkg::cp_drive_s cp_drive,
	output logic loop_filter_switch_pin_out,
	output logic loop_filter_switch_pin_oe,
	output logic signed [3:0] sdm_code
);
	import synth_ctrl_pkg::*;

	// ****************************************
	// Elaboration check
	// ****************************************
	if (MOD_W != 12)
	begin : g_bad_width
		$error("synth_ctrl supports a 12-bit modulus only");
	end

	// ****************************************
	// Declarations
	// ****************************************
	logic [MOD_W-1:0] frac, fractional_modulus, timer_value;
	logic [MOD_W-1:0] mod_eff, div_cnt, mod_cnt;
	logic cnt_rst, pwr_dn, slip_reduction, dither_en, hold, cell_source;
	logic freq_latch, slip_prev, over_prev, slip_ev, over_ev, fast_active;
	logic [1:0] div_mode;
	logic [2:0] sync1, sync2, sync3, pin_state, cells;
	slip_state_e slip_state;

	// ****************************************
	// Register field decode
	// ****************************************
	function automatic logic [MOD_W-1:0] word_field(
		input logic [31:0] w
	);
		word_field = w[`WORD_MSB:`WORD_LSB];
	endfunction : word_field

	assign hold = cnt_rst | pwr_dn;
	assign freq_latch = clk_en && reg_wr &&
		(reg_addr == `OFS_FREQ);

	assign mod_eff = (fractional_modulus < `MOD_MIN) ?
		`MOD_MIN : fractional_modulus;

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			frac <= '0;
			fractional_modulus <= `MOD_RESET;
			cnt_rst <= 1'b0;
			pwr_dn <= 1'b0;
			slip_reduction <= 1'b0;
			div_mode <= `DIV_MODE_OFF;
			timer_value <= '0;
			dither_en <= 1'b0;
		end
		else if (clk_en && reg_wr)
		begin
			case (reg_addr)
				`OFS_FREQ:
					frac <= word_field(reg_wdata);
				`OFS_MOD:
					fractional_modulus <= word_field(reg_wdata);
				`OFS_CTRL:
				begin
					cnt_rst <= reg_wdata[`CNT_RST_BIT];
					pwr_dn <= reg_wdata[`PWR_DN_BIT];
				end
				`OFS_TIMER:
				begin
					slip_reduction <= reg_wdata[`SLIP_EN_BIT];
					div_mode <=
						reg_wdata[`DIV_MODE_MSB:`DIV_MODE_LSB];
					timer_value <= word_field(reg_wdata);
				end
				`OFS_DITHER:
					dither_en <= reg_wdata[`DITHER_BIT];
				default:
					frac <= frac;
			endcase
		end
	end

	// ****************************************
	// Register reads, data one cycle later
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 32'h00000000;
		else if (clk_en)
		begin
			reg_rdata <= 32'h00000000;
			if (reg_rd)
			begin
				case (reg_addr)
					`OFS_FREQ:
						reg_rdata[`WORD_MSB:`WORD_LSB] <= frac;
					`OFS_MOD:
						reg_rdata[`WORD_MSB:`WORD_LSB] <=
							fractional_modulus;
					`OFS_CTRL:
					begin
						reg_rdata[`CNT_RST_BIT] <= cnt_rst;
						reg_rdata[`PWR_DN_BIT] <= pwr_dn;
					end
					`OFS_TIMER:
					begin
						reg_rdata[`SLIP_EN_BIT] <= slip_reduction;
						reg_rdata[`DIV_MODE_MSB:`DIV_MODE_LSB] <=
							div_mode;
						reg_rdata[`WORD_MSB:`WORD_LSB] <= timer_value;
					end
					`OFS_DITHER:
						reg_rdata[`DITHER_BIT] <= dither_en;
					`OFS_STATUS:
						reg_rdata[7:0] <= {cell_source, fast_active,
							slip_state, 1'b0, cells};
					default:
						reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
			pin_state <= 3'h0;
			slip_prev <= 1'b0;
			over_prev <= 1'b0;
		end
		else if (clk_en)
		begin
			sync1 <= {tune_up_pin, overshoot_pin, slip_near_pin};
			sync2 <= sync1;
			sync3 <= sync2;
			slip_prev <= pin_state[0];
			over_prev <= pin_state[1];
			for (int i = 0; i < 3; i++)
				if (sync2[i] == sync3[i])
					pin_state[i] <= sync3[i];
		end
	end

	assign slip_ev = pin_state[0] & ~slip_prev;
	assign over_ev = pin_state[1] & ~over_prev;

	// ****************************************
	// Cycle slip reduction sequencer
	// ****************************************
	// Releasing on PFD ticks keeps each step one loop update
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			slip_state <= SLIP_IDLE;
			cells <= 3'h0;
			cell_source <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!slip_reduction || hold)
			begin
				slip_state <= SLIP_IDLE;
				cells <= 3'h0;
			end
			else
			begin
				case (slip_state)
					SLIP_IDLE:
						if (slip_ev)
						begin
							cells <= 3'h1;
							cell_source <= pin_state[2];
							slip_state <= SLIP_RAMP;
						end
					SLIP_RAMP:
						if (over_ev)
							slip_state <= SLIP_RELEASE;
						else if (slip_ev && cells != `MAX_CELLS)
							cells <= cells + 3'h1;
					SLIP_RELEASE:
						if (cells == 3'h0)
							slip_state <= SLIP_IDLE;
						else if (pfd_tick)
							cells <= cells - 3'h1;
					default:
					begin
						slip_state <= SLIP_IDLE;
						cells <= 3'h0;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Fast-lock timer
	// ****************************************
	// Counts value x modulus PFD periods, not value periods
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fast_active <= 1'b0;
			div_cnt <= '0;
			mod_cnt <= '0;
		end
		else if (clk_en)
		begin
			if (hold || div_mode != `DIV_MODE_FAST)
				fast_active <= 1'b0;
			else if (freq_latch && timer_value != '0)
			begin
				fast_active <= 1'b1;
				div_cnt <= timer_value;
				mod_cnt <= mod_eff - 1'b1;
			end
			else if (fast_active && pfd_tick)
			begin
				if (mod_cnt != '0)
					mod_cnt <= mod_cnt - 1'b1;
				else
				begin
					mod_cnt <= mod_eff - 1'b1;
					div_cnt <= div_cnt - 1'b1;
					if (div_cnt == 12'h001)
						fast_active <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Outputs to the analog side
	// ****************************************
	// x16 current while wide
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cp_drive <= '0;
			loop_filter_switch_pin_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			cp_drive.boost_x16 <= fast_active;
			cp_drive.source <= cell_source;
			cp_drive.cells <= cells;
			loop_filter_switch_pin_oe <= fast_active;
		end
	end

	// Switch only ever sinks, so its driven level is always low
	assign loop_filter_switch_pin_out = 1'b0;

	// ****************************************
	// Sigma-delta modulator
	// ****************************************
	sigma_delta3 #(.MOD_W(MOD_W)) u_sdm (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.hold(hold),
		.advance(pfd_tick),
		.dither_en(dither_en),
		.modulus(mod_eff),
		.frac(frac),
		.code(sdm_code)
	);

endmodule : synth_ctrl

// file: verification/synth_ctrl_checker.sv
// Purpose: port-level checks of the synth control core
// Assumes: one clock, async active-high reset
// Notes: bound to the top module at the foot
`timescale 1ns/1ps
module synth_ctrl_checker #(
	parameter int MOD_W = 12
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic pfd_tick,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic slip_near_pin,
	input wire logic overshoot_pin,
	input wire logic tune_up_pin,
	input wire synth_ctrl_pkg::cp_drive_s cp_drive,
	input wire logic loop_filter_switch_pin_out,
	input wire logic loop_filter_switch_pin_oe,
	input wire logic signed [3:0] sdm_code
);
	import synth_ctrl_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic [1:0] mode;
	logic tmr_nz, held, wr_ok;
	assign wr_ok = clk_en && reg_wr;

	// ****************************************
	// Shadow of the fast-lock qualifiers
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			{mode, tmr_nz, held} <= 4'h0;
		else if (wr_ok && reg_addr == 8'h0c)
			{mode, tmr_nz} <= {reg_wdata[16:15], |reg_wdata[14:3]};
		else if (wr_ok && reg_addr == 8'h08)
			held <= reg_wdata[3] | reg_wdata[5];

	sequence fl_start;
		wr_ok && reg_addr == 8'h00 && mode == 2'h1 && tmr_nz && !held;
	endsequence
	sequence cells_kill;
		wr_ok && (reg_addr == 8'h0c && !reg_wdata[18] ||
			reg_addr == 8'h08 && (reg_wdata[3] || reg_wdata[5]));
	endsequence
	sequence mode_off;
		wr_ok && reg_addr == 8'h0c && reg_wdata[16:15] == 2'h0;
	endsequence

	// ****************************************
	// Assertions
	// ****************************************
	chk_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	chk_unmapped_zero: assert property (
		reg_rd && clk_en && (reg_addr > 8'h14 || reg_addr[1:0] != 2'h0)
		|=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_cells_step: assert property (
		cp_drive.cells != $past(cp_drive.cells) |->
		cp_drive.cells == 3'($past(cp_drive.cells) + 3'h1) ||
		3'(cp_drive.cells + 3'h1) == $past(cp_drive.cells) ||
		cp_drive.cells == 3'h0)
		else $error("cells moved by more than one");
	chk_cells_clear: assert property (
		cells_kill |-> ##[1:8] cp_drive.cells == 3'h0)
		else $error("cells not cleared");
	chk_boost_switch: assert property (
		cp_drive.boost_x16 == loop_filter_switch_pin_oe &&
		loop_filter_switch_pin_out == 1'b0)
		else $error("boost and switch disagree");
	chk_fast_start: assert property (
		fl_start |-> ##2 loop_filter_switch_pin_oe)
		else $error("fast lock did not start");
	chk_mode_off: assert property (
		mode_off |-> ##[1:3] !loop_filter_switch_pin_oe)
		else $error("fast lock not ended");
	chk_sdm_range: assert property (
		sdm_code >= -4'sh3 && sdm_code <= 4'sh4)
		else $error("modulator code out of range");
	chk_sdm_tick: assert property (
		$changed(sdm_code) && sdm_code != 4'sh0 |-> $past(pfd_tick))
		else $error("modulator moved without tick");
endmodule : synth_ctrl_checker

bind synth_ctrl synth_ctrl_checker #(.MOD_W(MOD_W)) u_chk (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.clk_en(clk_en),
	.pfd_tick(pfd_tick),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.slip_near_pin(slip_near_pin),
	.overshoot_pin(overshoot_pin),
	.tune_up_pin(tune_up_pin),
	.cp_drive(cp_drive),
	.loop_filter_switch_pin_out(loop_filter_switch_pin_out),
	.loop_filter_switch_pin_oe(loop_filter_switch_pin_oe),
	.sdm_code(sdm_code)
);

// file: verification/analog_side_model.sv
// Purpose: analog side: slip and overshoot detectors
// Assumes: detector pins are plain levels
// Notes: events are started by the bench
`timescale 1ns/1ps
module analog_side_model (
	input wire logic sys_clk,
	output logic slip_near_pin,
	output logic overshoot_pin,
	output logic tune_up_pin
);
	initial
	begin
		slip_near_pin = 1'b0;
		overshoot_pin = 1'b0;
		tune_up_pin = 1'b0;
	end

	// ****************************************
	// Detector events
	// ****************************************
	// Long pulse so the core's synchroniser sees it
	task automatic kick(logic over, logic up);
		@(posedge sys_clk);
		tune_up_pin <= up;
		if (over)
			overshoot_pin <= 1'b1;
		else
			slip_near_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		slip_near_pin <= 1'b0;
		overshoot_pin <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask : kick
endmodule : analog_side_model

// file: verification/synth_ctrl_tb.sv
// Purpose: self-checking bench of the synth control core
// Assumes: ticks are made by the bench, five clocks apart
// Notes: detector pins come from the analog side model
`timescale 1ns/1ps
module synth_ctrl_tb;
	import synth_ctrl_pkg::*;
	logic sys_clk, sys_rst, clk_en, pfd_tick, reg_wr, reg_rd;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic slip_near_pin, overshoot_pin, tune_up_pin, lf_out, lf_oe;
	cp_drive_s cp_drive;
	logic signed [3:0] sdm_code;
	logic signed [3:0] q[$];
	int num_errors, comparisons, n, s;

	synth_ctrl #(.MOD_W(12)) u_dut (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pfd_tick(pfd_tick),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.slip_near_pin(slip_near_pin),
		.overshoot_pin(overshoot_pin),
		.tune_up_pin(tune_up_pin),
		.cp_drive(cp_drive),
		.loop_filter_switch_pin_out(lf_out),
		.loop_filter_switch_pin_oe(lf_oe),
		.sdm_code(sdm_code)
	);
	analog_side_model u_ana (
		.sys_clk(sys_clk),
		.slip_near_pin(slip_near_pin),
		.overshoot_pin(overshoot_pin),
		.tune_up_pin(tune_up_pin)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Bus, tick and compare tasks
	// ****************************************
	task automatic chk(string w, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask : chk

	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd

	task automatic tick(int k);
		repeat (k)
		begin
			@(posedge sys_clk);
			pfd_tick <= 1'b1;
			@(posedge sys_clk);
			pfd_tick <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
	endtask : tick

	// Period check plus mean over one period; mean is checked only without dither
	task automatic seq(int m, int f, int dith, int l);
		wr(8'h10, 32'(dith));
		wr(8'h04, 32'(m << 3));
		wr(8'h00, 32'(f << 3));
		wr(8'h08, 32'h8);
		wr(8'h08, 32'h0);
		q.delete();
		tick(l);
		repeat (2 * l)
		begin
			tick(1);
			q.push_back(sdm_code);
		end
		n = 0;
		s = 0;
		for (int i = 0; i < l; i++)
		begin
			n += int'(q[i] !== q[i + l]);
			s += q[i];
		end
		if (dith != 0)
			chk("dither repeat", 32'h1, 32'(n > 0));
		else
		begin
			chk("repeat", 32'h0, 32'(n));
			chk("mean", 32'(f * l / m), 32'(s));
		end
	endtask : seq

	task automatic stop_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	initial
	begin
		#200000;
		num_errors++;
		stop_test();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		{pfd_tick, reg_wr, reg_rd} = 3'h0;
		clk_en = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		sys_rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(8'h04);
		chk("modulus reset", 32'h10, d);
		rd(8'h14);
		chk("status reset", 32'h0, d);
		wr(8'h04, 32'h7ff8);
		rd(8'h04);
		chk("modulus max", 32'h7ff8, d);
		rd(8'h40);
		chk("unmapped read", 32'h0, d);
		seq(7, 3, 0, 7);
		seq(8, 3, 0, 16);
		seq(9, 4, 0, 27);
		seq(12, 5, 0, 72);
		seq(64, 3, 1, 128);
		wr(8'h0c, 32'h40000);
		for (int i = 1; i <= 9; i++)
		begin
			u_ana.kick(1'b0, 1'b1);
			chk("cells up", 32'(i > 7 ? 7 : i), 32'(cp_drive.cells));
		end
		chk("source", 32'h1, 32'(cp_drive.source));
		u_ana.kick(1'b1, 1'b1);
		for (int i = 6; i >= 0; i--)
		begin
			tick(1);
			chk("cells down", 32'(i), 32'(cp_drive.cells));
		end
		u_ana.kick(1'b0, 1'b0);
		chk("sink cell", 32'h1, 32'(cp_drive));
		clk_en <= 1'b0;
		wr(8'h08, 32'h8);
		repeat (3) @(posedge sys_clk);
		chk("frozen", 32'h1, 32'(cp_drive));
		clk_en <= 1'b1;
		wr(8'h08, 32'h8);
		repeat (8) @(posedge sys_clk);
		chk("cells cleared", 32'h0, 32'(cp_drive));
		wr(8'h08, 32'h0);
		wr(8'h0c, 32'h0);
		u_ana.kick(1'b0, 1'b1);
		chk("slip disabled", 32'h0, 32'(cp_drive));
		wr(8'h04, 32'h28);
		wr(8'h0c, 32'h8018);
		wr(8'h00, 32'h8);
		repeat (2) @(posedge sys_clk);
		chk("fast lock", 32'h1, 32'(lf_oe));
		chk("boost", 32'h1, 32'(cp_drive.boost_x16));
		chk("switch level", 32'h0, 32'(lf_out));
		tick(10);
		wr(8'h00, 32'h8);
		n = 0;
		while (lf_oe === 1'b1 && n < 100)
		begin
			tick(1);
			n++;
		end
		chk("wide duration", 32'd15, 32'(n));
		chk("normal drive", 32'h0, 32'(cp_drive));
		wr(8'h00, 32'h8);
		wr(8'h08, 32'h20);
		rd(8'h08);
		chk("ctrl read", 32'h20, d);
		chk("power down", 32'h0, 32'(lf_oe));
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h8);
		wr(8'h0c, 32'h0);
		repeat (3) @(posedge sys_clk);
		chk("mode off", 32'h0, 32'(lf_oe));
		wr(8'h0c, 32'h8000);
		wr(8'h00, 32'h8);
		repeat (3) @(posedge sys_clk);
		chk("zero timer", 32'h0, 32'(lf_oe));
		stop_test();
	end
endmodule : synth_ctrl_tb
